// file: hdl/srf_framer.sv
// character boundary framer on the recovered serial bit stream
`timescale 1ns/1ns
`default_nettype none
module srf_framer #(
  parameter logic [9:0] SHORT_PAIR = 10'h17c,
  parameter logic [11:0] LONG_PAIR = 12'h5f0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic char_width_select,
  input wire logic reframe_enable,
  output logic char_valid,
  output logic [11:0] char_word
);
  import srf_pkg::*;

  typedef struct packed {
    logic [11:0] sh;
    logic [3:0] cnt;
    logic [11:0] word;
    logic cv;
    logic rf1;
    logic rf2;
  } srf_frm_st_t;

  srf_frm_st_t q, n;
  logic [11:0] sh_new;
  logic [3:0] wlast;
  logic hit;

  always_comb begin
    n = q;
    n.cv = 1'b0;
    sh_new = {q.sh[10:0], bit_in};
    wlast = char_width_select ? SHORT_LAST : LONG_LAST;
    hit = char_width_select ? (sh_new[9:0] == SHORT_PAIR)
                            : (sh_new == LONG_PAIR);
    if (bit_valid) begin
      n.sh = sh_new;
      // a sync pair only moves the boundary while reframing is allowed
      if ((q.rf2 && hit) || q.cnt == wlast) begin
        n.cv = 1'b1;
        n.cnt = 4'h0;
        n.word = char_width_select ? {2'h0, sh_new[9:0]} : sh_new;
        // enable is resampled on the character clock
        n.rf1 = reframe_enable;
        n.rf2 = q.rf1;
      end else begin
        n.cnt = q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign char_valid = q.cv;
  assign char_word = q.word;

  chk_frame_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bit_valid && !q.rf2 && q.cnt != wlast) |=> !char_valid)
    else $error("boundary moved while reframing disabled");
endmodule // srf_framer
`default_nettype wire

// file: hdl/srf_pkg.sv
// shared constants and carrier types for the receive framing control block
package srf_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STAT_OFF = 4'h4;
  localparam logic [3:0] VCNT_OFF = 4'h8;
  localparam int CTRL_POL_LSB = 0;
  localparam int CTRL_CBN_BIT = 2;
  localparam int CTRL_FBN_BIT = 3;
  localparam int CTRL_CWS_BIT = 4;
  localparam logic [1:0] POL_RST = 2'h0;
  localparam logic CBN_RST = 1'b1;
  localparam logic FBN_RST = 1'b1;
  localparam logic CWS_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int RST_SAMPLES = 7;
  localparam logic [8:0] LFSR_SEED = 9'h1ff;
  localparam logic [8:0] LAST_IDX = 9'h1fe;
  localparam int ERR_WIN = 28;
  localparam logic [4:0] ERR_LIMIT = 5'h0e;
  localparam int CHAR_W = 12;
  localparam logic [3:0] SHORT_LAST = 4'h9;
  localparam logic [3:0] LONG_LAST = 4'hb;

  typedef enum logic [3:0] {
    RS_IDLE = 4'h1,
    RS_RDCLR = 4'h2,
    RS_WRCLR = 4'h4,
    RS_HOLD = 4'h8
  } srf_rst_e_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic cmd;
    logic sync;
    logic [11:0] data;
  } srf_dec_t;

  typedef struct packed {
    logic wr;
    logic cmd;
    logic sync;
    logic [11:0] data;
  } srf_fwr_t;

  typedef struct packed {
    logic awvalid;
    logic [3:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [3:0] araddr;
    logic rready;
  } srf_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srf_axi_rsp_t;
endpackage

// file: hdl/srf_rx_ctrl.sv
// receive framing, discard, fifo reset and self-test control with axi-lite
`timescale 1ns/1ns
`default_nettype none
module srf_rx_ctrl #(
  parameter int RST_SAMPLES = srf_pkg::RST_SAMPLES,
  parameter logic [9:0] SHORT_PAIR = 10'h17c,
  parameter logic [11:0] LONG_PAIR = 12'h5f0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire srf_pkg::srf_axi_req_t s_axi_req,
  output srf_pkg::srf_axi_rsp_t s_axi_rsp,
  input wire logic ser_bit_valid,
  input wire logic ser_bit,
  input wire logic reframe_enable,
  output logic raw_char_valid,
  output logic [11:0] raw_char,
  input wire srf_pkg::srf_dec_t dec_i,
  input wire logic rx_selftest_enable_n,
  input wire logic rx_output_enable,
  input wire logic chip_select_n,
  input wire logic rx_fifo_reset_n,
  input wire logic fifo_empty_in,
  input wire logic fifo_full_in,
  output srf_pkg::srf_fwr_t fifo_wr_o,
  output logic fifo_rd_clr,
  output logic fifo_wr_clr,
  output logic [9:0] rx_parallel_word,
  output logic [1:0] rx_control_code,
  output logic rx_bus_oe,
  output logic code_violation_flag_o,
  output logic code_violation_flag_oe,
  output logic rx_fifo_empty_flag,
  output logic rx_fifo_full_flag
);
  import srf_pkg::*;

  if (RST_SAMPLES < 1 || RST_SAMPLES > 8) begin : g_bad_samples
    $error("RST_SAMPLES must lie in 1..8");
  end

  localparam logic [2:0] RCNT_LAST = 3'(RST_SAMPLES - 1);

  typedef struct packed {
    logic [1:0] pol;
    logic cbn;
    logic fbn;
    logic cws;
    logic st1;
    logic st2;
    logic cs_prev;
    logic sel;
    srf_rst_e_t rs;
    logic [2:0] rcnt;
    logic empty_hold;
    logic empty_o;
    logic full_o;
    logic vflag;
    logic [9:0] word;
    logic [1:0] code;
    logic stg_v;
    srf_dec_t stg;
    srf_fwr_t fwr;
    logic [8:0] lfsr;
    logic [8:0] idx;
    logic [27:0] hist;
    logic hold;
    logic fpulse;
    logic [15:0] vcnt;
    logic aw_got;
    logic w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srf_st_t;

  srf_st_t q, n;
  logic rsync1, rst_n;

  // reset enters asynchronously, released through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rsync1 <= 1'b1;
      rst_n <= rsync1;
    end
  end

  srf_framer #(
    .SHORT_PAIR(SHORT_PAIR),
    .LONG_PAIR(LONG_PAIR)
  ) u_framer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bit_valid(ser_bit_valid),
    .bit_in(ser_bit),
    .char_width_select(q.cws),
    .reframe_enable(reframe_enable),
    .char_valid(raw_char_valid),
    .char_word(raw_char)
  );

  function automatic logic [8:0] lfsr_step(input logic [8:0] v);
    return {v[7:0], v[8] ^ v[4]};
  endfunction

  function automatic logic [4:0] ones(input logic [27:0] v);
    logic [4:0] c;
    c = 5'h0;
    for (int i = 0; i < ERR_WIN; i++) begin
      c = c + {4'h0, v[i]};
    end
    return c;
  endfunction

  logic st_on, sy, em, mism, rst_cond;
  logic aw_ok, w_ok, ar_ok;
  srf_dec_t cur, e;
  logic [27:0] hist_new;

  assign rst_cond = q.fbn && !rx_output_enable && !chip_select_n
                    && !rx_fifo_reset_n;
  assign s_axi_rsp.awready = !q.aw_got && !q.bvalid;
  assign s_axi_rsp.wready = !q.w_got && !q.bvalid;
  assign s_axi_rsp.arready = !q.rvalid;
  assign s_axi_rsp.bvalid = q.bvalid;
  assign s_axi_rsp.bresp = q.bresp;
  assign s_axi_rsp.rvalid = q.rvalid;
  assign s_axi_rsp.rdata = q.rdata;
  assign s_axi_rsp.rresp = q.rresp;
  assign aw_ok = s_axi_req.awvalid && s_axi_rsp.awready;
  assign w_ok = s_axi_req.wvalid && s_axi_rsp.wready;
  assign ar_ok = s_axi_req.arvalid && s_axi_rsp.arready;

  always_comb begin
    n = q;
    st_on = !q.st2;
    sy = dec_i.sync && q.cbn;
    cur = dec_i;
    cur.sync = sy;
    e = cur;
    em = 1'b0;
    mism = 1'b0;
    hist_new = q.hist;
    n.fwr.wr = 1'b0;
    n.st1 = rx_selftest_enable_n;
    n.st2 = q.st1;
    // selection follows a chip-select cycle and ends with the enable
    n.cs_prev = !chip_select_n;
    if (!rx_output_enable) begin
      n.sel = 1'b0;
    end else if (q.cs_prev) begin
      n.sel = 1'b1;
    end

    if (dec_i.valid) begin
      n.vflag = 1'b0;
      n.fpulse = 1'b0;
      if (st_on) begin
        // self-test runs on the raw low byte, whatever the bypasses say
        if ((q.hold || dec_i.data[7:0] != q.lfsr[7:0])
            && dec_i.data[7:0] == LFSR_SEED[7:0]) begin
          n.lfsr = lfsr_step(LFSR_SEED);
          n.idx = 9'h1;
          n.hist = 28'h0;
          n.hold = 1'b0;
        end else begin
          mism = dec_i.data[7:0] != q.lfsr[7:0];
          hist_new = {q.hist[26:0], mism};
          n.hist = hist_new;
          n.lfsr = lfsr_step(q.lfsr);
          if (q.idx == LAST_IDX) begin
            n.idx = 9'h0;
            n.fpulse = 1'b1;
          end else begin
            n.idx = q.idx + 9'h1;
          end
          if (ones(hist_new) >= ERR_LIMIT) begin
            n.hold = 1'b1;
          end
        end
        n.vflag = mism;
      end else if (q.cbn && dec_i.err) begin
        // bad character: flag it, keep buses and the stream untouched
        n.vflag = 1'b1;
      end else begin
        case (q.pol)
          2'h0: begin
            em = 1'b1;
          end
          2'h1: begin
            // one character of delay decides whether a sync ends a run
            em = q.stg_v && !(q.stg.sync && sy);
            e = q.stg;
            n.stg = cur;
            n.stg_v = 1'b1;
          end
          default: begin
            em = !sy;
          end
        endcase
      end
    end

    if (em) begin
      if (e.cmd) begin
        n.code = e.data[11:10];
      end else begin
        n.word = e.data[9:0];
      end
      if (q.fbn && q.rs == RS_IDLE) begin
        n.fwr = {1'b1, e.cmd, e.sync, e.data};
        n.empty_hold = 1'b0;
      end
    end

    if (!q.cbn && !st_on) begin
      n.vflag = 1'b0;
    end

    case (q.rs)
      RS_IDLE: begin
        if (rst_cond) begin
          if (q.rcnt == RCNT_LAST) begin
            n.rs = RS_RDCLR;
            n.rcnt = 3'h0;
            n.empty_hold = 1'b1;
          end else begin
            n.rcnt = q.rcnt + 3'h1;
          end
        end else begin
          n.rcnt = 3'h0;
        end
      end
      RS_RDCLR: n.rs = RS_WRCLR;
      RS_WRCLR: n.rs = RS_HOLD;
      RS_HOLD: begin
        if (rx_fifo_reset_n) begin
          n.rs = RS_IDLE;
        end
      end
      default: n.rs = RS_IDLE;
    endcase
    if (!q.fbn) begin
      n.rs = RS_IDLE;
      n.rcnt = 3'h0;
    end

    // violation count: a new violation wins over a software clear
    if (n.vflag && dec_i.valid && n.vcnt != 16'hffff) begin
      n.vcnt = q.vcnt + 16'h1;
    end

    if (aw_ok) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_req.awaddr;
    end
    if (w_ok) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_req.wdata;
      n.wstrb = s_axi_req.wstrb;
    end
    if (q.aw_got && q.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (q.awaddr)
        CTRL_OFF: begin
          if (q.wstrb[0]) begin
            n.pol = q.wdata[CTRL_POL_LSB +: 2];
            n.cbn = q.wdata[CTRL_CBN_BIT];
            n.fbn = q.wdata[CTRL_FBN_BIT];
            n.cws = q.wdata[CTRL_CWS_BIT];
          end
        end
        STAT_OFF: ;
        VCNT_OFF: begin
          if (!(n.vflag && dec_i.valid)) begin
            n.vcnt = 16'h0;
          end else begin
            n.vcnt = 16'h1;
          end
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end else if (q.bvalid && s_axi_req.bready) begin
      n.bvalid = 1'b0;
    end

    if (ar_ok) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0;
      case (s_axi_req.araddr)
        CTRL_OFF: n.rdata = {27'h0, q.cws, q.fbn, q.cbn, q.pol};
        STAT_OFF: n.rdata = {22'h0, q.rs, q.hold, q.full_o,
                             q.empty_o, q.vflag, q.sel, !q.st2};
        VCNT_OFF: n.rdata = {16'h0, q.vcnt};
        default: n.rresp = RESP_SLVERR;
      endcase
    end else if (q.rvalid && s_axi_req.rready) begin
      n.rvalid = 1'b0;
    end

    n.empty_o = n.fbn ? (n.empty_hold || fifo_empty_in) : 1'b0;
    // self-test owns the full flag whatever the fifo bypass says
    n.full_o = !n.st2 ? (n.fpulse || n.hold)
                      : (n.fbn && fifo_full_in);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.pol <= POL_RST;
      q.cbn <= CBN_RST;
      q.fbn <= FBN_RST;
      q.cws <= CWS_RST;
      q.st1 <= 1'b1;
      q.st2 <= 1'b1;
      q.rs <= RS_IDLE;
      q.empty_hold <= 1'b1;
      q.empty_o <= 1'b1;
      q.lfsr <= LFSR_SEED;
    end else begin
      q <= n;
    end
  end

  assign fifo_wr_o = q.fwr;
  assign fifo_rd_clr = q.rs == RS_RDCLR;
  assign fifo_wr_clr = q.rs == RS_WRCLR;
  assign rx_parallel_word = q.word;
  assign rx_control_code = q.code;
  assign rx_bus_oe = q.sel;
  assign code_violation_flag_o = q.vflag;
  assign code_violation_flag_oe = q.sel;
  assign rx_fifo_empty_flag = q.empty_o;
  assign rx_fifo_full_flag = q.full_o;

  chk_viol_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dec_i.valid && dec_i.err && q.cbn && q.st2) |=> code_violation_flag_o)
    else $error("violation not flagged");
  chk_viol_bus_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dec_i.valid && dec_i.err && q.cbn && q.st2 && q.pol != 2'h1)
    |=> $stable(rx_parallel_word) && $stable(rx_control_code))
    else $error("bus changed on a violation");
  chk_viol_one_char: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$stable(q.vflag) |-> $past(dec_i.valid) || $past(!q.cbn))
    else $error("violation flag changed between characters");
  chk_bypass_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!q.cbn && q.st2) |=> !code_violation_flag_o)
    else $error("violation flag high in codec bypass");
  chk_oe_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rx_output_enable |=> !code_violation_flag_oe)
    else $error("flag driven while not selected");
  chk_reset_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.rs == RS_IDLE && q.rcnt == 3'h0 && rst_cond) ##1 rst_cond [*6]
    |=> fifo_rd_clr)
    else $error("fifo reset did not start");
  chk_clear_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fifo_rd_clr |-> rx_fifo_empty_flag ##1 fifo_wr_clr && !fifo_rd_clr)
    else $error("fifo clear order wrong");
  chk_empty_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.empty_hold && !n.fwr.wr && q.rs != RS_IDLE) |=> q.empty_hold)
    else $error("empty hold dropped without a write");
  chk_no_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.rs != RS_IDLE) |=> !fifo_wr_o.wr)
    else $error("character stored during fifo reset");
  chk_bypass_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !q.fbn |=> q.rs == RS_IDLE && !fifo_rd_clr)
    else $error("fifo reset acted in fifo bypass");
  chk_drop_sync: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fifo_wr_o.wr && q.pol[1]) |-> !fifo_wr_o.sync)
    else $error("sync stored under discard-all");
  chk_loop_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(q.fpulse) |-> $past(q.idx) == LAST_IDX)
    else $error("loop pulse off the last symbol");
  chk_err_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.hold && !q.st2) |-> rx_fifo_full_flag)
    else $error("full flag low while error hold");
endmodule // srf_rx_ctrl
`default_nettype wire

// file: verification/srf_host_model.sv
// host-side model driving selection and fifo reset request pins
`timescale 1ns/1ns
`default_nettype none
module srf_host_model (
  input wire logic sys_clk,
  input wire logic want_sel,
  input wire logic want_rst,
  output logic rx_output_enable,
  output logic chip_select_n,
  output logic rx_fifo_reset_n
);
  initial begin
    rx_output_enable = 1'b0;
    chip_select_n = 1'b1;
    rx_fifo_reset_n = 1'b1;
  end

  // a reset request drops the output enable, a reset needs it inactive
  always @(posedge sys_clk) begin
    rx_output_enable <= want_sel & ~want_rst;
    chip_select_n <= ~(want_sel | want_rst);
    rx_fifo_reset_n <= ~want_rst;
  end
endmodule // srf_host_model
`default_nettype wire

// file: verification/srf_rx_ctrl_tb.sv
// self-checking bench for the receive framing control block
`timescale 1ns/1ns
`default_nettype none
module srf_rx_ctrl_tb;
  import srf_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  srf_axi_req_t req = '0;
  srf_axi_rsp_t rsp;
  srf_dec_t dec = '0;
  srf_fwr_t fwr;
  localparam logic [9:0] PAIR = 10'h17c;
  logic st_n = 1'b1;
  logic ser_v = 1'b0;
  logic ser_b = 1'b0;
  logic rfe = 1'b0;
  logic rcv;
  logic [11:0] rch;
  logic want_sel = 1'b0;
  logic want_rst = 1'b0;
  logic oe_in, cs_n, frst_n, rd_clr, wr_clr, bus_oe, vf, vf_oe, empty, full;
  logic [9:0] word;
  logic [1:0] code;
  logic [1:0] resp;
  logic [31:0] rd;
  int failures = 0;
  int check_count = 0;
  int wr_cnt = 0;

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (fwr.wr === 1'b1) wr_cnt <= wr_cnt + 1;

  srf_host_model i_srf_host_model (.sys_clk(sys_clk), .want_sel(want_sel),
    .want_rst(want_rst), .rx_output_enable(oe_in), .chip_select_n(cs_n),
    .rx_fifo_reset_n(frst_n));

  // the bench owns the sync pair value so its framing checks stand alone
  srf_rx_ctrl #(.SHORT_PAIR(PAIR)) i_srf_rx_ctrl (.sys_clk(sys_clk),
    .reset_n(reset_n),
    .s_axi_req(req), .s_axi_rsp(rsp), .ser_bit_valid(ser_v), .ser_bit(ser_b),
    .reframe_enable(rfe), .raw_char_valid(rcv), .raw_char(rch), .dec_i(dec),
    .rx_selftest_enable_n(st_n), .rx_output_enable(oe_in),
    .chip_select_n(cs_n), .rx_fifo_reset_n(frst_n), .fifo_empty_in(1'b0),
    .fifo_full_in(1'b0), .fifo_wr_o(fwr), .fifo_rd_clr(rd_clr),
    .fifo_wr_clr(wr_clr), .rx_parallel_word(word), .rx_control_code(code),
    .rx_bus_oe(bus_oe), .code_violation_flag_o(vf),
    .code_violation_flag_oe(vf_oe), .rx_fifo_empty_flag(empty),
    .rx_fifo_full_flag(full));

  task automatic print_verdict;
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input string msg);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic hang(input string msg);
    failures++;
    $display("unexpected at %0t ns: %s timed out", $time, msg);
    print_verdict();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ready is sampled mid-cycle so the edge decision never races the slave
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    b = 1'b0;
    for (int n = 0; n < 20 && b !== 1'b1; n++) begin
      @(negedge sys_clk);
      aw = rsp.awready;
      w = rsp.wready;
      b = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge sys_clk);
      if (aw === 1'b1) req.awvalid <= 1'b0;
      if (w === 1'b1) req.wvalid <= 1'b0;
      if (b === 1'b1) req.bready <= 1'b0;
    end
    if (b !== 1'b1) hang("write");
  endtask

  task automatic axr(input logic [3:0] a);
    logic ar, r;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    r = 1'b0;
    for (int n = 0; n < 20 && r !== 1'b1; n++) begin
      @(negedge sys_clk);
      ar = rsp.arready;
      r = rsp.rvalid;
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge sys_clk);
      if (ar === 1'b1) req.arvalid <= 1'b0;
      if (r === 1'b1) req.rready <= 1'b0;
    end
    if (r !== 1'b1) hang("read");
  endtask

  // one decoded character; returns just after the edge that answers it
  task automatic chr(input logic e, input logic c, input logic s,
      input logic [11:0] d);
    @(posedge sys_clk);
    dec <= '{1'b1, e, c, s, d};
    @(posedge sys_clk);
    dec.valid <= 1'b0;
    #1;
  endtask

  // serial bits msb first; returns just after the edge that takes the last
  task automatic sbits(input logic [11:0] v, input int len);
    for (int i = len - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      ser_v <= 1'b1;
      ser_b <= v[i];
    end
    @(posedge sys_clk);
    ser_v <= 1'b0;
    #1;
  endtask

  task automatic t_frame;
    @(posedge sys_clk);
    rfe <= 1'b1;
    sbits(12'h0, 10);
    sbits(12'h0, 10);
    sbits(12'h0, 3);
    sbits({2'h0, PAIR}, 10);
    chk(rcv, 1'b1, "no character on sync pair");
    chk(rch, {2'h0, PAIR}, "boundary not moved to sync pair");
    @(posedge sys_clk);
    rfe <= 1'b0;
    sbits(12'h0, 10);
    sbits(12'h0, 10);
    sbits(12'h0, 3);
    sbits({2'h0, PAIR}, 10);
    chk(rcv, 1'b0, "boundary moved with reframing off");
  endtask

  task automatic watch(input int len, output int rat, output int wat);
    rat = 0;
    wat = 0;
    for (int n = 1; n <= len; n++) begin
      @(negedge sys_clk);
      if (rd_clr === 1'b1 && rat == 0) rat = n;
      if (wr_clr === 1'b1 && wat == 0) wat = n;
    end
  endtask

  task automatic t_regs;
    axr(CTRL_OFF);
    chk(rd[4:0], {CWS_RST, FBN_RST, CBN_RST, POL_RST}, "ctrl reset value");
    chk(resp, RESP_OKAY, "ctrl read response");
    axr(4'hc);
    chk(resp, RESP_SLVERR, "unmapped read response");
    axw(4'hc, 32'h1);
    chk(resp, RESP_SLVERR, "unmapped write response");
  endtask

  task automatic t_data;
    @(posedge sys_clk);
    want_sel <= 1'b1;
    cyc(4);
    #1;
    chk(vf_oe, 1'b1, "flag pin not driven when selected");
    chr(1'b0, 1'b0, 1'b0, 12'h2a5);
    chk(word, 10'h2a5, "data word");
    chk(fwr.wr, 1'b1, "data not stored");
    chr(1'b0, 1'b1, 1'b0, 12'hc00);
    chk(code, 2'h3, "control code");
    chr(1'b1, 1'b0, 1'b0, 12'h111);
    chk(vf, 1'b1, "violation missed");
    chk(word, 10'h2a5, "bus moved on violation");
    cyc(3);
    #1;
    chk(vf, 1'b1, "flag dropped inside its period");
    chr(1'b0, 1'b0, 1'b0, 12'h0f0);
    chk(vf, 1'b0, "flag outlived one period");
    @(posedge sys_clk);
    want_sel <= 1'b0;
    cyc(4);
    #1;
    chk(vf_oe, 1'b0, "flag pin driven when deselected");
  endtask

  task automatic t_bypass;
    axw(CTRL_OFF, 32'h18);
    chr(1'b1, 1'b0, 1'b0, 12'h222);
    chk(vf, 1'b0, "flag raised in codec bypass");
    axw(CTRL_OFF, 32'h1c);
  endtask

  task automatic t_frst;
    int rat, wat;
    // a run two short of the count must not start a reset
    @(posedge sys_clk);
    want_rst <= 1'b1;
    cyc(5);
    want_rst <= 1'b0;
    watch(12, rat, wat);
    chk(rat, 0, "reset from a broken run");
    @(posedge sys_clk);
    want_rst <= 1'b1;
    watch(20, rat, wat);
    chk(rat, 9, "reset start after seven samples");
    chk(wat, 10, "write side clear order");
    chk(empty, 1'b1, "empty flag in reset");
    chr(1'b0, 1'b0, 1'b0, 12'h033);
    chk(fwr.wr, 1'b0, "store while fifo held in reset");
    @(posedge sys_clk);
    want_rst <= 1'b0;
    cyc(4);
    #1;
    chk(empty, 1'b1, "empty dropped before a write");
    chr(1'b0, 1'b0, 1'b0, 12'h044);
    chk(fwr.wr, 1'b1, "no store after reset");
    axw(CTRL_OFF, 32'h14);
    @(posedge sys_clk);
    want_rst <= 1'b1;
    watch(15, rat, wat);
    chk(rat, 0, "reset honoured in fifo bypass");
    @(posedge sys_clk);
    want_rst <= 1'b0;
    axw(CTRL_OFF, 32'h1c);
  endtask

  task automatic t_pol;
    logic [1:0] pol [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int exp [4] = '{7, 3, 3, 4};
    logic [6:0] pat = 7'b1110100;
    int base;
    // policy 01 hands on each character one late, so the last stays inside
    for (int p = 0; p < 4; p++) begin
      axw(CTRL_OFF, {27'h0, 3'h7, pol[p]});
      base = wr_cnt;
      for (int i = 0; i < 7; i++) chr(1'b0, 1'b0, pat[6 - i], 12'(i));
      cyc(2);
      #1;
      chk(wr_cnt - base, exp[p], "stored count");
    end
  endtask

  task automatic t_self;
    logic [8:0] v;
    @(posedge sys_clk);
    st_n <= 1'b0;
    cyc(4);
    chr(1'b0, 1'b0, 1'b0, 12'h000);
    chk(vf, 1'b1, "mismatch not flagged");
    for (int i = 0; i < 29; i++) chr(1'b0, 1'b0, 1'b0, 12'h000);
    chk(full, 1'b1, "error hold missing");
    chr(1'b0, 1'b0, 1'b0, 12'h0ff);
    chk(full, 1'b0, "hold kept after pattern start");
    // true sequence: x^9+x^5+1 from an all-ones seed, low byte compared
    v = {LFSR_SEED[7:0], LFSR_SEED[8] ^ LFSR_SEED[4]};
    for (int i = 0; i < 509; i++) begin
      chr(1'b0, 1'b0, 1'b0, {4'h0, v[7:0]});
      v = {v[7:0], v[8] ^ v[4]};
    end
    chk(full, 1'b0, "full flag before loop end");
    chk(vf, 1'b0, "mismatch on true sequence");
    chr(1'b0, 1'b0, 1'b0, {4'h0, v[7:0]});
    chk(full, 1'b1, "loop end pulse missing");
    v = {v[7:0], v[8] ^ v[4]};
    chr(1'b0, 1'b0, 1'b0, {4'h0, v[7:0]});
    chk(full, 1'b0, "loop pulse too long");
    @(posedge sys_clk);
    st_n <= 1'b1;
  endtask

  initial begin
    cyc(2);
    reset_n <= 1'b1;
    cyc(4);
    t_regs();
    t_data();
    t_bypass();
    t_frst();
    t_pol();
    t_self();
    t_frame();
    print_verdict();
  end
endmodule // srf_rx_ctrl_tb
`default_nettype wire
